// ---- rtl/pxb_pkg.sv ----
// Constants shared by the port crossbar and its pin synchroniser.
package pxb_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_PINS  = 32;
  localparam int NUM_SIG   = 11;
  localparam int PIN_IDX_W = 5;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_PORT_DATA_BASE  = 8'h00;
  localparam logic [7:0] ADDR_LATCH_VIEW_BASE = 8'h10;
  localparam logic [7:0] ADDR_OUT_MODE_BASE   = 8'h20;
  localparam logic [7:0] ADDR_P1_INMODE       = 8'h30;
  localparam logic [7:0] ADDR_CFG_FIRST       = 8'h34;
  localparam logic [7:0] ADDR_CFG_SECOND      = 8'h38;
  localparam logic [7:0] ADDR_CFG_THIRD       = 8'h3c;
  localparam logic [7:0] ADDR_BIT_ACCESS      = 8'h40;
  localparam logic [7:0] ADDR_ALLOC_STATUS    = 8'h44;

  // ==========================================================================
  // Field positions
  localparam int CFG1_FIRST_UART_BIT   = 0;
  localparam int CFG1_SMBUS_BIT   = 1;
  localparam int CFG1_SPI_BIT     = 2;
  localparam int CFG2_SECOND_UART_BIT   = 0;
  localparam int CFG2_CNVSTR_BIT  = 1;
  localparam int CFG3_XBAR_EN_BIT = 0;
  localparam int CFG3_EMIF_LO_BIT = 1;
  localparam int CFG3_PUD_BIT     = 2;
  localparam int BIT_IDX_LSB      = 0;
  localparam int BIT_VAL_BIT      = 8;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] LATCH_RST    = 8'hff;
  localparam logic [7:0] OUT_MODE_RST = 8'h00;
  localparam logic [7:0] INMODE_RST   = 8'hff;
  localparam logic [7:0] CFG_RST      = 8'h00;

  // ==========================================================================
  // Peripheral signals in priority order, lowest index served first
  localparam int SIG_TX0  = 0;
  localparam int SIG_RX0  = 1;
  localparam int SIG_SDA  = 2;
  localparam int SIG_SCL  = 3;
  localparam int SIG_SCK  = 4;
  localparam int SIG_MISO = 5;
  localparam int SIG_MOSI = 6;
  localparam int SIG_NSS  = 7;
  localparam int SIG_TX1  = 8;
  localparam int SIG_RX1  = 9;
  localparam int SIG_CNV  = 10;
  localparam logic [10:0] SIG_IS_INPUT  = 11'h6a2;
  localparam logic [10:0] SIG_ALWAYS_OD = 11'h00c;

  // ==========================================================================
  // Fixed pin positions
  localparam int PIN_WR  = 7;
  localparam int PIN_RD  = 6;
  localparam int PIN_ALE = 5;
  localparam int P1_BASE = 8;

endpackage

// ---- rtl/pxb_pin_sync.sv ----
// Two-stage synchroniser for the port pin inputs.
`timescale 1ns/1ns
module pxb_pin_sync
  import pxb_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [NUM_PINS-1:0] pin_async,
  output logic      [NUM_PINS-1:0] pin_sync
);

  // ==========================================================================
  // Synchroniser chain
  logic [NUM_PINS-1:0] stage_one;

  // The first stage feeds only the second, so metastability never spreads.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_one <= '0;
      pin_sync  <= '0;
    end
    else
    begin
      stage_one <= pin_async;
      pin_sync  <= stage_one;
    end
  end

endmodule // pxb_pin_sync

// ---- rtl/pxb_crossbar.sv ----
// Port latches, priority crossbar and pin drivers for ports zero to three.
`timescale 1ns/1ns
module pxb_crossbar
  import pxb_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe,
  output logic      [NUM_PINS-1:0] pin_pullup_en,
  input  wire logic                first_uart_tx,
  output logic                     first_uart_rx,
  input  wire logic                first_uart_mode0,
  input  wire logic                smbus_sda_out,
  output logic                     smbus_sda_in,
  input  wire logic                smbus_scl_out,
  output logic                     smbus_scl_in,
  input  wire logic                spi_sck,
  output logic                     spi_miso,
  input  wire logic                spi_mosi,
  output logic                     spi_nss,
  input  wire logic                second_uart_tx,
  output logic                     second_uart_rx,
  input  wire logic                second_uart_mode0,
  output logic                     second_adc_convert_strobe,
  input  wire logic                emif_active,
  input  wire logic                emif_muxed_mode,
  input  wire logic [NUM_PINS-1:0] emif_pin_mask,
  input  wire logic [NUM_PINS-1:0] emif_pin_out,
  input  wire logic [NUM_PINS-1:0] emif_pin_oe,
  output logic                     emif_upper_select
);

  // ==========================================================================
  // Storage and wiring
  logic [NUM_PINS-1:0]  latch;
  logic [NUM_PINS-1:0]  out_mode;
  logic [7:0]           p1_inmode;
  logic [7:0]           crossbar_config_first;
  logic [7:0]           crossbar_config_second;
  logic [7:0]           crossbar_config_third;
  logic [NUM_PINS-1:0]  pin_sync;
  logic [NUM_PINS-1:0]  pin_read;
  logic [NUM_PINS-1:0]  analog_mask;
  logic [NUM_PINS-1:0]  skip;
  logic [NUM_PINS-1:0]  emif_take;
  logic [NUM_PINS-1:0]  pin_owned;
  logic [NUM_PINS-1:0]  pin_is_in;
  logic [NUM_PINS-1:0]  pin_val;
  logic [NUM_PINS-1:0]  pin_od;
  logic [NUM_PINS-1:0]  next_pin_out;
  logic [NUM_PINS-1:0]  next_pin_oe;
  logic [NUM_PINS-1:0]  next_pin_pullup;
  logic [NUM_SIG-1:0]   sig_en;
  logic [NUM_SIG-1:0]   sig_out;
  logic [NUM_SIG-1:0]   sig_od;
  logic [NUM_SIG-1:0]   sig_ok;
  logic [NUM_SIG-1:0]   sig_in_q;
  logic [PIN_IDX_W-1:0] sig_pin [NUM_SIG];
  logic                 crossbar_global_enable;
  logic                 ext_mem_low_port_select;
  logic                 pullup_global_disable;
  logic                 wr_access;
  logic                 rd_setup;
  logic [4:0]           byte_base;
  logic [31:0]          next_rdata;
  logic                 next_err;

  assign crossbar_global_enable  = crossbar_config_third[CFG3_XBAR_EN_BIT];
  assign ext_mem_low_port_select = crossbar_config_third[CFG3_EMIF_LO_BIT];
  assign pullup_global_disable   = crossbar_config_third[CFG3_PUD_BIT];
  assign emif_upper_select       = !ext_mem_low_port_select;

  // ==========================================================================
  // Pin input synchroniser
  pxb_pin_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (pin_in),
    .pin_sync  (pin_sync)
  );

  // Analog port-one pins read as zero and are kept out of allocation.
  assign analog_mask = {16'h0000, ~p1_inmode, 8'h00};
  assign pin_read    = pin_sync & ~analog_mask;

  // The memory interface overrides its pins only while a move is running.
  assign emif_take = {NUM_PINS{emif_active && ext_mem_low_port_select}} & emif_pin_mask;

  // ==========================================================================
  // APB slave: zero wait states, read data captured in the setup cycle.
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup  = psel && !penable;
  assign byte_base = {paddr[3:2], 3'b000};

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (paddr[1:0] != 2'b00)
      next_err = 1'b1;
    else if (paddr[7:4] == ADDR_PORT_DATA_BASE[7:4])
      next_rdata[7:0] = pin_read[byte_base +: 8];
    else if (paddr[7:4] == ADDR_LATCH_VIEW_BASE[7:4])
      next_rdata[7:0] = latch[byte_base +: 8];
    else if (paddr[7:4] == ADDR_OUT_MODE_BASE[7:4])
      next_rdata[7:0] = out_mode[byte_base +: 8];
    else if (paddr == ADDR_P1_INMODE)
      next_rdata[7:0] = p1_inmode;
    else if (paddr == ADDR_CFG_FIRST)
      next_rdata[7:0] = crossbar_config_first;
    else if (paddr == ADDR_CFG_SECOND)
      next_rdata[7:0] = crossbar_config_second;
    else if (paddr == ADDR_CFG_THIRD)
      next_rdata[7:0] = crossbar_config_third;
    else if (paddr == ADDR_BIT_ACCESS)
      next_rdata = 32'h0000_0000;
    else if (paddr == ADDR_ALLOC_STATUS)
      next_rdata = pin_owned;
    else
      next_err = 1'b1;
  end

  // Registering at setup keeps prdata a flop output with no extra wait.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata  <= next_rdata;
      pslverr <= next_err;
    end
  end

  // Port latches: byte writes through either view, or one bit at a time.
  // A latch under a claimed pin still stores, it just does not reach the pin.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch <= {4{LATCH_RST}};
    else if (wr_access && paddr[1:0] == 2'b00 &&
             (paddr[7:4] == ADDR_PORT_DATA_BASE[7:4] ||
              paddr[7:4] == ADDR_LATCH_VIEW_BASE[7:4]))
      latch[byte_base +: 8] <= pwdata[7:0];
    else if (wr_access && paddr == ADDR_BIT_ACCESS)
      latch[pwdata[BIT_IDX_LSB +: PIN_IDX_W]] <= pwdata[BIT_VAL_BIT];
  end

  // Output mode bits, open-drain after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_mode <= {4{OUT_MODE_RST}};
    else if (wr_access && paddr[1:0] == 2'b00 && paddr[7:4] == ADDR_OUT_MODE_BASE[7:4])
      out_mode[byte_base +: 8] <= pwdata[7:0];
  end

  // Crossbar configuration and port-one input modes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p1_inmode              <= INMODE_RST;
      crossbar_config_first  <= CFG_RST;
      crossbar_config_second <= CFG_RST;
      crossbar_config_third  <= CFG_RST;
    end
    else if (wr_access)
    begin
      if (paddr == ADDR_P1_INMODE)
        p1_inmode <= pwdata[7:0];
      else if (paddr == ADDR_CFG_FIRST)
        crossbar_config_first <= pwdata[7:0];
      else if (paddr == ADDR_CFG_SECOND)
        crossbar_config_second <= pwdata[7:0];
      else if (paddr == ADDR_CFG_THIRD)
        crossbar_config_third <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Priority crossbar
  // One enable covers every signal of a serial peripheral.
  assign sig_en = {crossbar_config_second[CFG2_CNVSTR_BIT],
                   {2{crossbar_config_second[CFG2_SECOND_UART_BIT]}},
                   {4{crossbar_config_first[CFG1_SPI_BIT]}},
                   {2{crossbar_config_first[CFG1_SMBUS_BIT]}},
                   {2{crossbar_config_first[CFG1_FIRST_UART_BIT]}}};

  // Pure inputs contribute a dummy one that is never driven.
  assign sig_out = {1'b1, 1'b1, second_uart_tx, 1'b1, spi_mosi, 1'b1, spi_sck,
                    smbus_scl_out, smbus_sda_out, 1'b1, first_uart_tx};

  // Signals that must never drive high, whatever the mode bits say.
  always_comb
  begin
    sig_od          = SIG_ALWAYS_OD;
    sig_od[SIG_RX0] = first_uart_mode0;
    sig_od[SIG_RX1] = second_uart_mode0;
  end

  // Pins lost to analog inputs and to low-port memory strobes.
  always_comb
  begin
    skip = analog_mask;
    if (ext_mem_low_port_select)
    begin
      skip[PIN_WR] = 1'b1;
      skip[PIN_RD] = 1'b1;
      if (emif_muxed_mode)
        skip[PIN_ALE] = 1'b1;
    end
  end

  // Each enabled signal takes the lowest free, non-skipped pin. The search
  // is combinational, so a configuration change reshuffles pins at once;
  // software is expected to set this up before enabling the drivers.
  always_comb
  begin
    logic found;
    found     = 1'b0;
    pin_owned = '0;
    pin_is_in = '0;
    pin_val   = '0;
    pin_od    = '0;
    sig_ok    = '0;
    for (int s = 0; s < NUM_SIG; s++)
    begin
      sig_pin[s] = '0;
      found      = 1'b0;
      if (sig_en[s])
      begin
        for (int p = 0; p < NUM_PINS; p++)
        begin
          if (!found && !skip[p] && !pin_owned[p])
          begin
            found        = 1'b1;
            pin_owned[p] = 1'b1;
            pin_is_in[p] = SIG_IS_INPUT[s];
            pin_val[p]   = sig_out[s];
            pin_od[p]    = sig_od[s];
            sig_ok[s]    = 1'b1;
            sig_pin[s]   = PIN_IDX_W'(p);
          end
        end
      end
    end
  end

  // Peripheral inputs see their pin only while routed; idle level is high.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sig_in_q <= '1;
    else
      for (int s = 0; s < NUM_SIG; s++)
        sig_in_q[s] <= (crossbar_global_enable && sig_ok[s]) ?
                       pin_sync[sig_pin[s]] : 1'b1;
  end

  assign first_uart_rx             = sig_in_q[SIG_RX0];
  assign smbus_sda_in              = sig_in_q[SIG_SDA];
  assign smbus_scl_in              = sig_in_q[SIG_SCL];
  assign spi_miso                  = sig_in_q[SIG_MISO];
  assign spi_nss                   = sig_in_q[SIG_NSS];
  assign second_uart_rx            = sig_in_q[SIG_RX1];
  assign second_adc_convert_strobe = sig_in_q[SIG_CNV];

  // ==========================================================================
  // Pin drivers
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pin
    logic val;
    logic push_pull;
    logic drive;

    always_comb
    begin
      if (emif_take[p])
      begin
        val       = emif_pin_out[p];
        push_pull = 1'b0;
        drive     = crossbar_global_enable && emif_pin_oe[p];
      end
      else
      begin
        val       = pin_owned[p] ? pin_val[p] : latch[p];
        push_pull = out_mode[p] && !pin_od[p];
        drive     = crossbar_global_enable && !pin_is_in[p] &&
                    (!val || push_pull);
      end
    end

    assign next_pin_out[p]    = val;
    // A pin pulling low would only fight its own pullup.
    assign next_pin_pullup[p] = !pullup_global_disable && !(drive && !val) &&
                                !analog_mask[p];
    assign next_pin_oe[p]     = drive;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out       <= '1;
      pin_oe        <= '0;
      pin_pullup_en <= '1;
    end
    else
    begin
      pin_out       <= next_pin_out;
      pin_oe        <= next_pin_oe;
      pin_pullup_en <= next_pin_pullup;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup_read(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  sequence s_bit_write;
    psel && penable && pwrite && paddr == ADDR_BIT_ACCESS;
  endsequence

  drivers_off_a: assert property (!crossbar_global_enable |=> pin_oe == 32'h0)
    else $error("pin driver on while crossbar disabled");

  uart_tx_low_a: assert property (
    crossbar_global_enable && crossbar_config_first[CFG1_FIRST_UART_BIT] &&
    !first_uart_tx && !emif_take[0] |=> pin_oe[0] && !pin_out[0])
    else $error("first uart transmit not on pin zero");

  rx_driver_off_a: assert property (
    crossbar_config_first[CFG1_FIRST_UART_BIT] && !emif_take[1] |=> !pin_oe[1])
    else $error("receive pin driven");

  bit_write_a: assert property (
    s_bit_write |=> latch[$past(pwdata[4:0])] == $past(pwdata[8]))
    else $error("bit write did not reach latch");

  pushpull_high_a: assert property (
    crossbar_global_enable && out_mode[31] && latch[31] && !emif_take[31]
    |=> pin_oe[31] && pin_out[31])
    else $error("push-pull pin not driven high");

  opendrain_off_a: assert property (
    crossbar_global_enable && !out_mode[31] && latch[31] && !emif_take[31]
    |=> !pin_oe[31] && pin_pullup_en[31] == !$past(pullup_global_disable))
    else $error("open-drain pin not released");

  forced_od_a: assert property (
    (next_pin_oe & next_pin_out & pin_owned & pin_od & ~emif_take) == 32'h0)
    else $error("forced open-drain pin driven high");

  pin_read_a: assert property (
    s_setup_read(ADDR_PORT_DATA_BASE) |=> prdata[7:0] == $past(pin_read[7:0]))
    else $error("port read not pin level");

  latch_view_a: assert property (
    s_setup_read(ADDR_LATCH_VIEW_BASE) |=> prdata[7:0] == $past(latch[7:0]))
    else $error("latch view read wrong");

  analog_read_a: assert property (
    s_setup_read(ADDR_PORT_DATA_BASE + 8'h04) |=> (prdata[7:0] & ~$past(p1_inmode)) == 8'h00)
    else $error("analog pin read not zero");

  strobe_skip_a: assert property (
    ext_mem_low_port_select |-> !pin_owned[PIN_WR] && !pin_owned[PIN_RD])
    else $error("memory strobe pin allocated");

endmodule // pxb_crossbar

// ---- test/pxb_board_model.sv ----
// Board-side model of the wires on ports zero to three.
`timescale 1ns/1ns
module pxb_board_model
  import pxb_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic [NUM_PINS-1:0] pin_out,
  input  wire logic [NUM_PINS-1:0] pin_oe,
  input  wire logic [NUM_PINS-1:0] pin_pullup_en,
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_val,
  output logic      [NUM_PINS-1:0] pin_level
);
  // ==========================================================
  // Wire resolution
  logic [NUM_PINS-1:0] last = '0;

  // A wire nobody holds and no pullup lifts flips each cycle, so a stale value never passes.
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (pin_pullup_en[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = ~last[i];
    end
  end

  // Last level seen, used for floating wires.
  always_ff @(posedge pclk)
    last <= pin_level;
endmodule // pxb_board_model

// ---- test/port_io_priority_crossbar_bench.sv ----
// Self-checking bench for the port crossbar over APB.
`timescale 1ns/1ns
module port_io_priority_crossbar_bench;
  import pxb_pkg::*;
  // ==========================================================
  // Signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic pready, pslverr, rerr;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [NUM_PINS-1:0] ext_en = '0, ext_val = '0, emask = '0, eout = '0, eoe = '0;
  logic tx0 = 1, rx0, sda = 1, sdai, scl = 1, scli, sck = 1, miso, mosi = 1, nss;
  logic tx1 = 1, rx1, cnv, eact = 0, emux = 0, eup, m0 = 0;
  int err_total = 0, samples_checked = 0;

  `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

  always #10 pclk = ~pclk;

  // ==========================================================
  // Instances
  pxb_crossbar uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .first_uart_tx(tx0), .first_uart_rx(rx0),
    .first_uart_mode0(m0), .smbus_sda_out(sda), .smbus_sda_in(sdai),
    .smbus_scl_out(scl), .smbus_scl_in(scli), .spi_sck(sck), .spi_miso(miso),
    .spi_mosi(mosi), .spi_nss(nss), .second_uart_tx(tx1), .second_uart_rx(rx1),
    .second_uart_mode0(m0), .second_adc_convert_strobe(cnv), .emif_active(eact),
    .emif_muxed_mode(emux), .emif_pin_mask(emask), .emif_pin_out(eout),
    .emif_pin_oe(eoe), .emif_upper_select(eup));

  pxb_board_model board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rdat)
  endtask

  // Pin outputs lag by an edge and pin reads by three, so let them settle.
  task automatic settle();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask

  initial
  begin
    #1000000;
    err_total++;
    stop_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ADDR_LATCH_VIEW_BASE, 32'h0000_00ff);
    rd_chk(ADDR_OUT_MODE_BASE, 32'h0);
    rd_chk(ADDR_P1_INMODE, 32'h0000_00ff);
    settle();
    `CHK("oe", 32'h0, pin_oe)
    `CHK("pullup", 32'hffff_ffff, pin_pullup_en)
    `CHK("rx0", 1'b1, rx0)
    $display("test reset done");
    // Latch low before the global enable must not drive anything.
    wr(ADDR_PORT_DATA_BASE, 32'h0);
    settle();
    `CHK("oe", 32'h0, pin_oe)
    rd_chk(ADDR_PORT_DATA_BASE, 32'h0000_00ff);
    rd_chk(ADDR_LATCH_VIEW_BASE, 32'h0);
    wr(ADDR_PORT_DATA_BASE, 32'h0000_00ff);
    wr(ADDR_CFG_THIRD, 32'h1);
    wr(ADDR_PORT_DATA_BASE, 32'h0000_00fe);
    settle();
    `CHK("oe0", 1'b1, pin_oe[0])
    `CHK("out0", 1'b0, pin_out[0])
    `CHK("pu0", 1'b0, pin_pullup_en[0])
    wr(ADDR_BIT_ACCESS, 32'h0000_0100);
    settle();
    `CHK("oe0", 1'b0, pin_oe[0])
    wr(ADDR_OUT_MODE_BASE, 32'h1);
    wr(ADDR_OUT_MODE_BASE + 8'h0c, 32'h0000_0080);
    settle();
    `CHK("oe0", 1'b1, pin_oe[0])
    `CHK("oe31", 1'b1, pin_oe[31])
    `CHK("out0", 1'b1, pin_out[0])
    $display("test gpio done");
    // Crossbar set up first, then the peripheral starts driving.
    wr(ADDR_CFG_FIRST, 32'h1);
    wr(ADDR_PORT_DATA_BASE, 32'h0000_00fc);
    tx0 <= 1'b0;
    ext_en[1] <= 1'b1;
    settle();
    `CHK("out0", 1'b0, pin_out[0])
    `CHK("oe1", 1'b0, pin_oe[1])
    `CHK("rx0", 1'b0, rx0)
    @(posedge pclk);
    tx0 <= 1'b1;
    settle();
    `CHK("out0", 1'b1, pin_out[0])
    rd_chk(ADDR_PORT_DATA_BASE, 32'h0000_00fd);
    rd_chk(ADDR_LATCH_VIEW_BASE, 32'h0000_00fc);
    rd_chk(ADDR_ALLOC_STATUS, 32'h3);
    $display("test uart done");
    wr(ADDR_OUT_MODE_BASE, 32'h0000_00ff);
    wr(ADDR_CFG_FIRST, 32'h7);
    sck <= 1'b0;
    mosi <= 1'b0;
    scl <= 1'b0;
    ext_en[5] <= 1'b1;
    m0 <= 1'b1;
    settle();
    `CHK("oe2", 1'b0, pin_oe[2])
    `CHK("oe1", 1'b0, pin_oe[1])
    `CHK("miso", 1'b0, miso)
    `CHK("scli", 1'b0, scli)
    `CHK("nss", 1'b1, nss)
    `CHK("oe3", 1'b1, pin_oe[3])
    `CHK("out4", 1'b0, pin_out[4])
    `CHK("oe5", 1'b0, pin_oe[5])
    `CHK("out6", 1'b0, pin_out[6])
    rd_chk(ADDR_ALLOC_STATUS, 32'h0000_00ff);
    $display("test serial done");
    // Memory strobes and an analog pin push the second UART receive to pin nine.
    wr(ADDR_CFG_FIRST, 32'h3);
    wr(ADDR_CFG_SECOND, 32'h1);
    wr(ADDR_P1_INMODE, 32'h0000_00fe);
    ext_en[15:8] <= 8'hff;
    ext_val[15:8] <= 8'hfd;
    emux <= 1'b1;
    tx1 <= 1'b0;
    wr(ADDR_CFG_THIRD, 32'h7);
    settle();
    `CHK("out4", 1'b0, pin_out[4])
    `CHK("pullup", 32'h0, pin_pullup_en)
    `CHK("upper", 1'b0, eup)
    `CHK("rx1", 1'b0, rx1)
    `CHK("cnv", 1'b1, cnv)
    rd_chk(ADDR_ALLOC_STATUS, 32'h0000_021f);
    rd_chk(ADDR_PORT_DATA_BASE + 8'h4, 32'h0000_00fc);
    $display("test skip done");
    emask[7] <= 1'b1;
    eout[7] <= 1'b0;
    eoe[7] <= 1'b1;
    eact <= 1'b1;
    settle();
    `CHK("out7", 1'b0, pin_out[7])
    @(posedge pclk);
    eact <= 1'b0;
    settle();
    `CHK("out7", 1'b1, pin_out[7])
    $display("test memory done");
    apb(1'b0, 8'h50, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    apb(1'b1, 8'h01, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    rd_chk(ADDR_LATCH_VIEW_BASE, 32'h0000_00fc);
    $display("test refused done");
    stop_test();
  end
endmodule // port_io_priority_crossbar_bench
